/* File: dv/color_path_props.sv */
`timescale 1ns/10ps
module color_path_props
    import color_path_pkg::*;
(
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             rst_n,
    // Control and pixel handshakes
    input wire logic             ctrl_wr,
    input wire logic [7:0]       ctrl_addr,
    input wire logic [7:0]       ctrl_data,
    input wire logic             pix_valid,
    input wire logic             pix_ready,
    // Output bus
    input wire logic             out_valid,
    input wire logic             out_ready,
    input wire logic [PIX_W-1:0] green_channel_output_bus,
    input wire logic [PIX_W-1:0] blue_channel_output_bus,
    input wire logic [PIX_W-1:0] red_channel_output_bus,
    input wire logic             out_fmt_422
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    sequence s_fmt_wr;
        ctrl_wr && ctrl_addr == CTRL_ADDR_FMT;
    endsequence

    chk_reset_clear: assert property (
        disable iff (1'b0) !rst_n |=> !out_valid && !pix_ready && !out_fmt_422)
        else $error("outputs not cleared by reset");
    chk_valid_hold: assert property (s_stall |=> out_valid)
        else $error("word dropped while stalled");
    chk_data_hold: assert property (s_stall |=>
        $stable(green_channel_output_bus) && $stable(blue_channel_output_bus)
        && $stable(red_channel_output_bus))
        else $error("bus changed while stalled");
    chk_red_idle: assert property (
        out_valid && out_fmt_422 |-> red_channel_output_bus == 10'h000)
        else $error("red bus busy in packed format");
    chk_fmt_take: assert property (s_fmt_wr |-> ##2
        out_fmt_422 == $past(ctrl_data[CTRL_BIT_FMT], 2))
        else $error("format bit not taken");
    chk_fmt_cause: assert property (
        $changed(out_fmt_422) && $past(rst_n) |->
        $past(ctrl_wr, 2) && $past(ctrl_addr, 2) == CTRL_ADDR_FMT)
        else $error("format changed without a write");
    chk_out_latency: assert property (
        pix_valid && pix_ready |-> ##[1:4] out_valid)
        else $error("taken pixel produced no word");
    chk_ready_start: assert property (
        $rose(rst_n) |-> ##[1:3] pix_ready)
        else $error("input never ready after reset");
endmodule : color_path_props

bind color_path color_path_props u_props (.sys_clk, .rst_n, .ctrl_wr,
    .ctrl_addr, .ctrl_data, .pix_valid, .pix_ready, .out_valid, .out_ready,
    .green_channel_output_bus, .blue_channel_output_bus,
    .red_channel_output_bus, .out_fmt_422);

/* File: dv/color_path_tb.sv */
`timescale 1ns/10ps
module color_path_tb
    import color_path_pkg::*;
;
    logic sys_clk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, coef_wr = 1'b0;
    logic pix_valid = 1'b0, line_start = 1'b0, slow = 1'b0;
    logic [7:0] ctrl_addr = 8'h00, ctrl_data = 8'h00;
    logic [COEF_IDXW-1:0] coef_idx = 4'h0;
    logic [COEF_W-1:0] coef_data = 16'h0000;
    logic [PIX_W-1:0] pix_r = 10'h000, pix_g = 10'h000, pix_b = 10'h000;
    logic pix_ready, out_valid, out_ready, out_fmt_422;
    logic [PIX_W-1:0] g_bus, b_bus, r_bus;
    int bad_count = 0, tests_run = 0, stalls;
    // Expected matrix, G B R per row
    logic signed [15:0] coef[9] = '{16'sh16E3, 16'sh024F, 16'sh06CE,
        16'shF3AB, 16'sh1000, 16'shFC55, 16'shF178, 16'shFE88, 16'sh1000};

    always #10 sys_clk = ~sys_clk;

    color_path u_dut (.sys_clk, .rst_n, .ctrl_wr, .ctrl_addr, .ctrl_data,
        .coef_wr, .coef_idx, .coef_data, .pix_valid, .line_start, .pix_r,
        .pix_g, .pix_b, .pix_ready, .out_valid, .out_ready,
        .green_channel_output_bus(g_bus), .blue_channel_output_bus(b_bus),
        .red_channel_output_bus(r_bus), .out_fmt_422);
    video_sink u_sink (.sys_clk, .rst_n, .out_valid, .g_bus, .b_bus, .r_bus,
        .out_ready, .slow);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] mat(int row, logic [9:0] g, b, r);
        int s;
        s = coef[3*row] * int'(g) + coef[3*row+1] * int'(b);
        s = s + coef[3*row+2] * int'(r);
        s = ((s + 32'sh800) >>> 12) + (row == 0 ? 0 : 32'sh200);
        if (s < 0) s = 0;
        if (s > 32'sh3FF) s = 32'sh3FF;
        return s[9:0];
    endfunction : mat

    task automatic verify(input bit ok, input string what);
        tests_run++;
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : verify

    task automatic ctrl(input logic [7:0] a, d);
        @(negedge sys_clk);
        {ctrl_wr, ctrl_addr, ctrl_data} = {1'b1, a, d};
        @(negedge sys_clk);
        ctrl_wr = 1'b0;
    endtask : ctrl

    task automatic cwr(input logic [3:0] i, input logic [15:0] d);
        @(negedge sys_clk);
        {coef_wr, coef_idx, coef_data} = {1'b1, i, d};
        if (i < 4'h9) coef[i] = d;
        @(negedge sys_clk);
        coef_wr = 1'b0;
    endtask : cwr

    // One line of 60 like pixels; words before 26 still see older pixels
    task automatic run(input logic [9:0] g, b, r);
        u_sink.words.delete();
        stalls = 0;
        for (int i = 0; i < 60; i++) begin
            @(negedge sys_clk);
            {pix_valid, line_start} = {1'b1, i == 0};
            {pix_g, pix_b, pix_r} = {g, b, r};
            // Ready is settled here and holds up to the taking edge
            for (int t = 0; t < 100 && pix_ready !== 1'b1; t++) begin
                @(negedge sys_clk);
                stalls++;
            end
            @(posedge sys_clk);
        end
        @(negedge sys_clk);
        {pix_valid, line_start} = 2'b00;
        for (int t = 0; t < 2000; t++) begin
            if (u_sink.words.size() >= 60) break;
            @(posedge sys_clk);
        end
    endtask : run

    task automatic judge(input logic [9:0] ey, ecb, ecr, input bit f422);
        logic [29:0] e;
        verify(u_sink.words.size() == 60, "word count");
        for (int k = 26; k < 60; k++) begin
            e = {ey, (f422 && k % 2 == 0) ? ecr : ecb,
                 f422 ? 10'h000 : ecr};
            verify(u_sink.words[k] === e, "pixel word");
        end
    endtask : judge

    ////////////////////////////////////////////////////////////////////////
    task automatic t_bypass;
        run(10'h123, 10'h0AA, 10'h055);
        judge(10'h123, 10'h0AA, 10'h055, 1'b0);
    endtask : t_bypass

    task automatic t_matrix_hd;
        ctrl(8'h18, 8'h00);
        run(10'h040, 10'h080, 10'h020);
        judge(mat(0, 10'h040, 10'h080, 10'h020),
              mat(1, 10'h040, 10'h080, 10'h020),
              mat(2, 10'h040, 10'h080, 10'h020), 1'b0);
    endtask : t_matrix_hd

    // Standard-definition luma row loaded by the host
    task automatic t_sd;
        cwr(4'h0, 16'h12C9);
        cwr(4'h1, 16'h03A6);
        cwr(4'h2, 16'h0991);
        run(10'h010, 10'h100, 10'h010);
        judge(mat(0, 10'h010, 10'h100, 10'h010),
              mat(1, 10'h010, 10'h100, 10'h010),
              mat(2, 10'h010, 10'h100, 10'h010), 1'b0);
    endtask : t_sd

    task automatic t_coef;
        for (int i = 0; i < 9; i++) begin
            cwr(i[3:0], i % 4 == 0 ? 16'h1000 : 16'h0000);
        end
        cwr(4'h8, 16'hF000);
        cwr(4'h9, 16'h7FFF);
        run(10'h2C0, 10'h3F0, 10'h010);
        judge(10'h2C0, 10'h3FF, 10'h1F0, 1'b0);
    endtask : t_coef

    // Slow sink: output words must survive while input is pushed back
    task automatic t_packed;
        ctrl(8'h15, 8'h02);
        slow = 1'b1;
        run(10'h100, 10'h0F0, 10'h020);
        judge(10'h100, 10'h2F0, 10'h1E0, 1'b1);
        verify(stalls > 0, "input never pushed back");
        verify(out_fmt_422 === 1'b1, "format flag not shown");
        slow = 1'b0;
    endtask : t_packed

    task automatic wrap_up;
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_bypass();
        t_matrix_hd();
        t_sd();
        t_coef();
        t_packed();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        wrap_up();
    end
endmodule : color_path_tb

/* File: dv/video_sink.sv */
`timescale 1ns/10ps
module video_sink
    import color_path_pkg::*;
(
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             rst_n,
    // Pixel bus
    input wire logic             out_valid,
    input wire logic [PIX_W-1:0] g_bus,
    input wire logic [PIX_W-1:0] b_bus,
    input wire logic [PIX_W-1:0] r_bus,
    output logic                 out_ready,
    // Pace
    input wire logic             slow
);
    logic [1:0]         phase_q = 2'h0;
    logic [3*PIX_W-1:0] words[$];

    // One word in four when slow, so the FIFO fills and pushes back
    always @(negedge sys_clk) begin
        phase_q = phase_q + 2'h1;
        out_ready = !slow || phase_q == 2'h0;
        // Bus is settled here and is what the coming rising edge accepts
        if (rst_n && out_valid && out_ready) begin
            words.push_back({g_bus, b_bus, r_bus});
        end
    end
endmodule : video_sink

/* File: shared/color_path_pkg.sv */
package color_path_pkg;

    // Sample and coefficient widths
    localparam int PIX_W     = 10;
    localparam int COEF_W    = 16;
    localparam int COEF_N    = 9;
    localparam int COEF_IDXW = 4;
    localparam int COEF_FRAC = 12;   // 16'h1000 is a gain of one

    // Control subaddresses and bit positions
    localparam logic [7:0] CTRL_ADDR_FMT    = 8'h15;
    localparam int         CTRL_BIT_FMT     = 1;
    localparam logic [7:0] CTRL_ADDR_BYPASS = 8'h18;
    localparam int         CTRL_BIT_BYPASS  = 4;

    // Reset values of the control bits
    localparam logic RST_BYPASS  = 1'b1;
    localparam logic RST_FMT_422 = 1'b0;

    // Output offsets and range
    localparam logic signed [31:0] LUMA_OFS   = 32'sh0;
    localparam logic signed [31:0] CHROMA_OFS = 32'sh200;
    localparam logic signed [31:0] PIX_MAX    = 32'sh3FF;

    // Matrix order: row Y, Cb, Cr; within a row G, B, R
    localparam logic [COEF_N-1:0][COEF_W-1:0] COEF_HD = {
        16'h1000, 16'hFE88, 16'hF178,
        16'hFC55, 16'h1000, 16'hF3AB,
        16'h06CE, 16'h024F, 16'h16E3
    };

    // Half-band decimation filter, index is distance from centre
    localparam int HB_TAPS   = 27;
    localparam int HB_CENTRE = 13;
    localparam int HB_FRAC   = 10;
    localparam logic [HB_CENTRE:0][11:0] HB_COEF = {
        12'h002, 12'h000, 12'hFFA, 12'h000, 12'h00E, 12'h000, 12'hFE5,
        12'h000, 12'h031, 12'h000, 12'hFA0, 12'h000, 12'h140, 12'h200
    };

    localparam int FIFO_DEPTH  = 8;
    localparam int FIFO_MARGIN = 4;

endpackage : color_path_pkg

/* File: verilog/color_path.sv */
// Functional notes
// - RGB becomes Y, Cb, Cr via a 3x3 matrix of nine host-written weights.
// - Reset loads the HD set; luma row G, B, R = 16E3, 024F, 06CE.
// - HD Cb row G, B, R = F3AB, 1000, FC55; the blue weight is unity.
// - Bit 4 of subaddress 18h bypasses the matrix; on after reset.
// - A 27-tap half-band filter can halve the 4:4:4 chroma rate.
// - Bit 1 of subaddress 15h picks 30-bit 4:4:4 or 20-bit 4:2:2 output.
// - In 4:2:2, Cb and Cr share the blue channel output bus in time.
// - Chroma decimation follows the matrix, so it sees YCbCr samples.
// - Luma always leaves on the green bus with Y9 on its top line.
`timescale 1ns/10ps
module color_path
    import color_path_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Control writes from the serial interface
    input  wire logic                 ctrl_wr,
    input  wire logic [7:0]           ctrl_addr,
    input  wire logic [7:0]           ctrl_data,
    input  wire logic                 coef_wr,
    input  wire logic [COEF_IDXW-1:0] coef_idx,
    input  wire logic [COEF_W-1:0]    coef_data,
    // Pixels from the converters
    input  wire logic                 pix_valid,
    input  wire logic                 line_start,
    input  wire logic [PIX_W-1:0]     pix_r,
    input  wire logic [PIX_W-1:0]     pix_g,
    input  wire logic [PIX_W-1:0]     pix_b,
    output logic                      pix_ready,
    // Pixel bus to the video processor
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [PIX_W-1:0]          green_channel_output_bus,
    output logic [PIX_W-1:0]          blue_channel_output_bus,
    output logic [PIX_W-1:0]          red_channel_output_bus,
    output logic                      out_fmt_422
);
    localparam int DW = 3 * PIX_W;
    localparam int CW = $clog2(FIFO_DEPTH+1);

    typedef logic [HB_TAPS-1:0][PIX_W-1:0] line_type;

    typedef struct packed {
        logic [COEF_N-1:0][COEF_W-1:0] coef;
        logic                          bypass;
        logic                          fmt_422;
        logic                          line_odd;
        logic                          s1_valid;
        logic                          s1_even;
        logic [PIX_W-1:0]              s1_y;
        logic [PIX_W-1:0]              s1_cb;
        logic [PIX_W-1:0]              s1_cr;
        line_type                      dl_y;
        line_type                      dl_cb;
        line_type                      dl_cr;
        logic [HB_TAPS-1:0]            dl_even;
        logic [PIX_W-1:0]              cr_hold;
        logic                          s2_valid;
        logic [DW-1:0]                 s2_data;
        logic                          in_ready;
        logic                          out_valid;
        logic [DW-1:0]                 out_data;
        logic                          out_fmt;
    } core_state_type;

    core_state_type q;
    core_state_type n;
    logic           fifo_rd_valid;
    logic [DW-1:0]  fifo_rd_data;
    logic           fifo_rd_ready;
    logic [CW-1:0]  fifo_count;
    logic           take;
    logic           odd;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    function automatic logic [PIX_W-1:0] clip(input logic signed [31:0] v);
        if (v < 0) begin
            clip = '0;
        end else if (v > PIX_MAX) begin
            clip = PIX_MAX[PIX_W-1:0];
        end else begin
            clip = v[PIX_W-1:0];
        end
    endfunction : clip

    // One matrix row; the rounding term is half an output step
    function automatic logic [PIX_W-1:0] mat_row(
        input logic [PIX_W-1:0]  g,
        input logic [PIX_W-1:0]  b,
        input logic [PIX_W-1:0]  r,
        input logic [COEF_W-1:0] kg,
        input logic [COEF_W-1:0] kb,
        input logic [COEF_W-1:0] kr,
        input logic signed [31:0] ofs
    );
        logic signed [31:0] acc;
        acc = $signed({1'b0, g}) * $signed(kg)
            + $signed({1'b0, b}) * $signed(kb)
            + $signed({1'b0, r}) * $signed(kr)
            + (32'sd1 <<< (COEF_FRAC - 1));
        mat_row = clip((acc >>> COEF_FRAC) + ofs);
    endfunction : mat_row

    // Half-band: only the centre and odd distances are nonzero
    function automatic logic [PIX_W-1:0] halfband(input line_type l);
        logic signed [31:0] acc;
        int                 d;
        acc = 32'sd1 <<< (HB_FRAC - 1);
        for (int k = 0; k < HB_TAPS; k++) begin
            d   = (k > HB_CENTRE) ? k - HB_CENTRE : HB_CENTRE - k;
            acc = acc + $signed({1'b0, l[k]}) * $signed(HB_COEF[d]);
        end
        halfband = clip(acc >>> HB_FRAC);
    endfunction : halfband

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n    = q;
        take = pix_valid & q.in_ready;
        odd  = line_start ? 1'b0 : q.line_odd;

        // Control and coefficient writes
        if (ctrl_wr && ctrl_addr == CTRL_ADDR_BYPASS) begin
            n.bypass = ctrl_data[CTRL_BIT_BYPASS];
        end else if (ctrl_wr && ctrl_addr == CTRL_ADDR_FMT) begin
            n.fmt_422 = ctrl_data[CTRL_BIT_FMT];
        end
        if (coef_wr && coef_idx < COEF_IDXW'(COEF_N)) begin
            n.coef[coef_idx] = coef_data;
        end

        // Stage 1: colour matrix or pass-through
        n.s1_valid = take;
        if (take) begin
            n.line_odd = ~odd;
            n.s1_even  = ~odd;
            if (q.bypass) begin
                n.s1_y  = pix_g;
                n.s1_cb = pix_b;
                n.s1_cr = pix_r;
            end else begin
                n.s1_y  = mat_row(pix_g, pix_b, pix_r, q.coef[0],
                                  q.coef[1], q.coef[2], LUMA_OFS);
                n.s1_cb = mat_row(pix_g, pix_b, pix_r, q.coef[3],
                                  q.coef[4], q.coef[5], CHROMA_OFS);
                n.s1_cr = mat_row(pix_g, pix_b, pix_r, q.coef[6],
                                  q.coef[7], q.coef[8], CHROMA_OFS);
            end
        end

        // Stage 2: delay lines fed from the matrix output
        n.s2_valid = q.s1_valid;
        if (q.s1_valid) begin
            n.dl_y    = {q.dl_y[HB_TAPS-2:0], q.s1_y};
            n.dl_cb   = {q.dl_cb[HB_TAPS-2:0], q.s1_cb};
            n.dl_cr   = {q.dl_cr[HB_TAPS-2:0], q.s1_cr};
            n.dl_even = {q.dl_even[HB_TAPS-2:0], q.s1_even};
            // Luma is taken at the centre so it stays aligned with chroma
            n.s2_data[DW-1 -: PIX_W] = n.dl_y[HB_CENTRE];
            if (q.fmt_422) begin
                n.s2_data[PIX_W-1:0] = '0;
                if (n.dl_even[HB_CENTRE]) begin
                    n.s2_data[2*PIX_W-1 -: PIX_W] =
                        halfband(n.dl_cb);
                    n.cr_hold = halfband(n.dl_cr);
                end else begin
                    n.s2_data[2*PIX_W-1 -: PIX_W] = q.cr_hold;
                end
            end else begin
                n.s2_data[2*PIX_W-1 -: PIX_W] = n.dl_cb[HB_CENTRE];
                n.s2_data[PIX_W-1:0]          = n.dl_cr[HB_CENTRE];
            end
        end

        // Ready leaves room for every pixel already inside the pipe
        n.in_ready = (int'(fifo_count) <= FIFO_DEPTH - FIFO_MARGIN);

        // Output register drained from the FIFO
        fifo_rd_ready = ~q.out_valid | out_ready;
        if (fifo_rd_ready) begin
            n.out_valid = fifo_rd_valid;
            if (fifo_rd_valid) begin
                n.out_data = fifo_rd_data;
            end
        end
        n.out_fmt = q.fmt_422;

        if (!rst_n) begin
            n         = '0;
            n.coef    = COEF_HD;
            n.bypass  = RST_BYPASS;
            n.fmt_422 = RST_FMT_422;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer; a stalled consumer backs up to pix_ready

    pixel_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .wr_valid (q.s2_valid),
        .wr_data  (q.s2_data),
        .wr_ready (),
        .rd_valid (fifo_rd_valid),
        .rd_data  (fifo_rd_data),
        .rd_ready (fifo_rd_ready),
        .count    (fifo_count)
    );

    assign pix_ready                = q.in_ready;
    assign out_valid                = q.out_valid;
    assign green_channel_output_bus = q.out_data[DW-1 -: PIX_W];
    assign blue_channel_output_bus  = q.out_data[2*PIX_W-1 -: PIX_W];
    assign red_channel_output_bus   = q.out_data[PIX_W-1:0];
    assign out_fmt_422              = q.out_fmt;

endmodule : color_path

/* File: verilog/pixel_fifo.sv */
`timescale 1ns/10ps
module pixel_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Fill side
    input  wire logic                       wr_valid,
    input  wire logic [WIDTH-1:0]           wr_data,
    output logic                            wr_ready,
    // Drain side
    output logic                            rd_valid,
    output logic [WIDTH-1:0]                rd_data,
    input  wire logic                       rd_ready,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [CW-1:0]               cnt;
    } fifo_state_type;

    fifo_state_type q;
    fifo_state_type n;
    logic           push;
    logic           pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    always_comb begin
        n        = q;
        wr_ready = (q.cnt != CW'(DEPTH));
        rd_valid = (q.cnt != '0);
        rd_data  = q.mem[q.rptr];
        count    = q.cnt;
        push     = wr_valid & wr_ready;
        pop      = rd_valid & rd_ready;
        if (push) begin
            n.mem[q.wptr] = wr_data;
            n.wptr        = bump(q.wptr);
        end
        if (pop) begin
            n.rptr = bump(q.rptr);
        end
        if (push && !pop) begin
            n.cnt = CW'(q.cnt + 1'b1);
        end else if (pop && !push) begin
            n.cnt = CW'(q.cnt - 1'b1);
        end
        if (!rst_n) begin
            n = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= n;
    end

endmodule : pixel_fifo
